// ==== cssc_handler.v ====
// common status and control command handler: status registers, masks,
// output slot, completion sync, reset and self-test sequencing
// assumes commands arrive parsed, one per valid/ready handshake
//
// Behaviour
// - clear-status clears status data and both completion idle states
// - clear-status right after a terminator also flushes output queue
// - event-enable set rounds 0..255 parameter and loads mask bits
// - out-of-range event-enable parameter raises an execution error
// - event-enable query returns mask as integer 0..255
// - event-status query returns register 0..255 and clears it
// - identification answers four fields: maker, model, serial, firmware
// - completion command sets completion event bit once ops finish
// - completion query queues ascii one once ops finish, event untouched
// - reset puts device functions known, macros default and disabled
// - reset keeps queue, enables, event registers, service enable
// - service-enable set loads 0..255 mask with bit 6 ignored
// - service-enable query returns mask with bit 6 reading zero
// - status-byte query returns byte with summary status in bit 6
// - self-test runs, queues result, then restores prior settings
// - self-test result is -32767..32767, zero meaning pass
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defs.vh"

module cssc_handler #(
  parameter [15:0] MAKER_ID    = 16'h00a1, // arbitrary value
  parameter [15:0] MODEL_ID    = 16'h00b2, // arbitrary value
  parameter [15:0] SERIAL_ID   = 16'h00c3, // arbitrary value
  parameter [15:0] FIRMWARE_ID = 16'h00d4  // arbitrary value
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // parsed command stream
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [3:0]  cmd_code,
  input  wire [15:0] cmd_param,
  input  wire        cmd_param_half,
  input  wire        cmd_after_term,
  // output queue slot
  output reg         out_valid,
  input  wire        out_read,
  output reg  [15:0] out_data,
  output reg  [1:0]  out_kind,
  output reg         out_more,
  // device side status
  input  wire [7:0]  event_in,
  input  wire [7:0]  status_in,
  input  wire        ops_pending,
  // device reset and macros
  output reg         dev_reset_pulse,
  output reg         macro_enable,
  output reg         macro_default_pulse,
  // self-test link
  output reg         test_start,
  input  wire        test_done,
  input  wire [15:0] test_result,
  output reg         settings_save,
  output reg         settings_restore,
  // register views
  output wire [7:0]  event_enable_mask,
  output wire [7:0]  event_status_latch,
  output wire [7:0]  service_enable_mask,
  output wire [7:0]  summary_status_byte
);

  // sequencer states, one-hot
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_IDN  = 3'h2;
  localparam [2:0] ST_TST  = 3'h4;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [1:0]  idn_idx_q;
  reg  [7:0]  ese_q;
  reg  [7:0]  esr_q;
  reg  [7:0]  sre_q;
  reg         opc_armed_q;
  reg         opcq_armed_q;
  reg  [15:0] idn_field;
  wire        accept;
  wire        is_query;
  wire        param_bad;
  wire [15:0] param_round;
  wire [7:0]  stb_low;
  wire        mss;
  wire        ops_idle;

  // queries need an empty slot or one being read; plain commands skip the slot check
  assign is_query  = (cmd_code == `CSSC_CMD_ESE_QRY) ||
                     (cmd_code == `CSSC_CMD_ESR_QRY) ||
                     (cmd_code == `CSSC_CMD_IDN_QRY) ||
                     (cmd_code == `CSSC_CMD_SRE_QRY) ||
                     (cmd_code == `CSSC_CMD_STB_QRY) ||
                     (cmd_code == `CSSC_CMD_TST_QRY) ||
                     (cmd_code == `CSSC_CMD_OPC_QRY);
  // a waiting completion query holds off all but clear-status and reset,
  // so those two can still return it to idle
  assign cmd_ready = (state_q == ST_IDLE) &&
                     (!opcq_armed_q || cmd_code == `CSSC_CMD_CLS ||
                      cmd_code == `CSSC_CMD_RST) &&
                     (!is_query || !out_valid || out_read);
  assign accept    = cmd_valid && cmd_ready;
  assign ops_idle  = !ops_pending;

  // round half up, then range check on the signed value
  assign param_round = cmd_param + {15'h0000, cmd_param_half};
  assign param_bad   = cmd_param_half &&
                       ($signed(cmd_param) == $signed(`CSSC_PARAM_MAX)) ?
                       1'b1 :
                       (($signed(cmd_param) < $signed(`CSSC_PARAM_MIN)) ||
                        ($signed(cmd_param) > $signed(`CSSC_PARAM_MAX)));

  // status byte: bit 6 recomputed, never taken from the device inputs
  assign stb_low = {status_in[7], 1'b0, |(esr_q & ese_q), out_valid,
                    status_in[3:0]};
  assign mss     = |(stb_low & sre_q & 8'hbf);
  assign summary_status_byte = stb_low | {1'b0, mss, 6'h00};
  assign event_enable_mask   = ese_q;
  assign event_status_latch  = esr_q;
  assign service_enable_mask = sre_q;

  // identification field mux, maker first
  always @*
  begin
    case (idn_idx_q)
      2'h0:    idn_field = MAKER_ID;
      2'h1:    idn_field = MODEL_ID;
      2'h2:    idn_field = SERIAL_ID;
      default: idn_field = FIRMWARE_ID;
    endcase
  end

  // sequencer next state
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept && cmd_code == `CSSC_CMD_IDN_QRY)
          state_d = ST_IDN;
        else if (accept && cmd_code == `CSSC_CMD_TST_QRY)
          state_d = ST_TST;
      end
      ST_IDN:
      begin
        if ((!out_valid || out_read) && idn_idx_q == 2'h3)
          state_d = ST_IDLE;
      end
      ST_TST:
      begin
        if (test_done)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // state and identification index
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q   <= ST_IDLE;
      idn_idx_q <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDN && (!out_valid || out_read))
        idn_idx_q <= idn_idx_q + 2'h1;
      else if (state_q != ST_IDN)
        idn_idx_q <= 2'h0;
    end
  end

  // enable masks; the reset command leaves both alone
  always @(posedge clk)
  begin
    if (reset)
    begin
      ese_q <= `CSSC_RST_MASK;
      sre_q <= `CSSC_RST_MASK;
    end
    else if (accept && !param_bad)
    begin
      if (cmd_code == `CSSC_CMD_ESE_SET)
        ese_q <= param_round[7:0];
      if (cmd_code == `CSSC_CMD_SRE_SET)
        sre_q <= param_round[7:0] & 8'hbf;
    end
  end

  // event status: new events and the error win over any clear
  always @(posedge clk)
  begin
    if (reset)
      esr_q <= `CSSC_RST_ESR;
    else
    begin
      if (accept && (cmd_code == `CSSC_CMD_CLS ||
                     cmd_code == `CSSC_CMD_ESR_QRY))
        esr_q <= event_in;
      else
        esr_q <= esr_q | event_in;
      if (accept && param_bad && (cmd_code == `CSSC_CMD_ESE_SET ||
                                  cmd_code == `CSSC_CMD_SRE_SET))
        esr_q[`CSSC_ESR_EXE] <= 1'b1;
      if (opc_armed_q && ops_idle)
        esr_q[`CSSC_ESR_OPC] <= 1'b1;
    end
  end

  // completion arming; clear-status and reset return both to idle
  always @(posedge clk)
  begin
    if (reset)
    begin
      opc_armed_q  <= 1'b0;
      opcq_armed_q <= 1'b0;
    end
    else if (accept && (cmd_code == `CSSC_CMD_CLS ||
                        cmd_code == `CSSC_CMD_RST))
    begin
      opc_armed_q  <= 1'b0;
      opcq_armed_q <= 1'b0;
    end
    else
    begin
      if (accept && cmd_code == `CSSC_CMD_OPC)
        opc_armed_q <= 1'b1;
      else if (opc_armed_q && ops_idle)
        opc_armed_q <= 1'b0;
      if (accept && cmd_code == `CSSC_CMD_OPC_QRY)
        opcq_armed_q <= 1'b1;
      else if (opcq_armed_q && ops_idle && (!out_valid || out_read))
        opcq_armed_q <= 1'b0;
    end
  end

  // output slot; a fresh response overwrites only a slot being read
  always @(posedge clk)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
      out_kind  <= `CSSC_KIND_NUM;
      out_more  <= 1'b0;
    end
    else
    begin
      if (out_read)
        out_valid <= 1'b0;
      if (accept && cmd_code == `CSSC_CMD_CLS && cmd_after_term)
        out_valid <= 1'b0;
      if (accept)
      begin
        out_kind <= `CSSC_KIND_NUM;
        out_more <= 1'b0;
        case (cmd_code)
          `CSSC_CMD_ESE_QRY:
          begin
            out_valid <= 1'b1;
            out_data  <= {8'h00, ese_q};
          end
          `CSSC_CMD_ESR_QRY:
          begin
            out_valid <= 1'b1;
            out_data  <= {8'h00, esr_q};
          end
          `CSSC_CMD_SRE_QRY:
          begin
            out_valid <= 1'b1;
            out_data  <= {8'h00, sre_q & 8'hbf};
          end
          `CSSC_CMD_STB_QRY:
          begin
            out_valid <= 1'b1;
            out_data  <= {8'h00, summary_status_byte};
          end
          default:
          begin
            out_data <= out_data;
          end
        endcase
      end
      else if (state_q == ST_IDN && (!out_valid || out_read))
      begin
        out_valid <= 1'b1;
        out_data  <= idn_field;
        out_kind  <= `CSSC_KIND_IDN;
        out_more  <= (idn_idx_q != 2'h3);
      end
      else if (state_q == ST_TST && test_done)
      begin
        out_valid <= 1'b1;
        // clamp keeps -32768 out of the reported range
        out_data  <= (test_result == 16'h8000) ? 16'h8001 :
                     test_result;
        out_kind  <= `CSSC_KIND_NUM;
        out_more  <= 1'b0;
      end
      else if (opcq_armed_q && ops_idle && (!out_valid || out_read))
      begin
        out_valid <= 1'b1;
        out_data  <= `CSSC_ASCII_ONE;
        out_kind  <= `CSSC_KIND_CHAR;
        out_more  <= 1'b0;
      end
    end
  end

  // reset command, macro control and self-test strobes
  always @(posedge clk)
  begin
    if (reset)
    begin
      dev_reset_pulse     <= 1'b0;
      macro_default_pulse <= 1'b0;
      macro_enable        <= 1'b1;
      test_start          <= 1'b0;
      settings_save       <= 1'b0;
      settings_restore    <= 1'b0;
    end
    else
    begin
      dev_reset_pulse     <= accept && cmd_code == `CSSC_CMD_RST;
      macro_default_pulse <= accept && cmd_code == `CSSC_CMD_RST;
      if (accept && cmd_code == `CSSC_CMD_RST)
        macro_enable <= 1'b0;
      // settings saved before the test starts, restored once it ends
      settings_save    <= accept && cmd_code == `CSSC_CMD_TST_QRY;
      test_start       <= settings_save;
      settings_restore <= state_q == ST_TST && test_done;
    end
  end

endmodule
`default_nettype wire

// ==== cssc_defs.vh ====
// constants for the common status command handler
// assumes inclusion by bare name from the design file
`ifndef CSSC_DEFS_VH
`define CSSC_DEFS_VH

// command codes presented on cmd_code
`define CSSC_CMD_CLS      4'h0
`define CSSC_CMD_ESE_SET  4'h1
`define CSSC_CMD_ESE_QRY  4'h2
`define CSSC_CMD_ESR_QRY  4'h3
`define CSSC_CMD_IDN_QRY  4'h4
`define CSSC_CMD_OPC      4'h5
`define CSSC_CMD_OPC_QRY  4'h6
`define CSSC_CMD_RST      4'h7
`define CSSC_CMD_SRE_SET  4'h8
`define CSSC_CMD_SRE_QRY  4'h9
`define CSSC_CMD_STB_QRY  4'ha
`define CSSC_CMD_TST_QRY  4'hb

// response kinds on out_kind
`define CSSC_KIND_NUM     2'h0
`define CSSC_KIND_CHAR    2'h1
`define CSSC_KIND_IDN     2'h2

// standard event status bit positions
`define CSSC_ESR_OPC      0
`define CSSC_ESR_EXE      4

// status byte bit positions
`define CSSC_STB_MAV      4
`define CSSC_STB_ESB      5
`define CSSC_STB_MSS      6

// parameter range for the mask set commands
`define CSSC_PARAM_MIN    16'sh0000
`define CSSC_PARAM_MAX    16'sh00ff

// ascii one for the completion query
`define CSSC_ASCII_ONE    16'h0031

// reset values of the registers
`define CSSC_RST_MASK     8'h00
`define CSSC_RST_ESR      8'h00

`endif

// ==== cssc_monitor.sv ====
// checker for the common status command handler ports
// assumes a bind onto cssc_handler, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defs.vh"
module cssc_monitor (
  // watched ports
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [3:0]  cmd_code,
  input wire logic [15:0] cmd_param,
  input wire logic        out_valid,
  input wire logic [15:0] out_data,
  input wire logic [7:0]  event_in,
  input wire logic        ops_pending,
  input wire logic        test_done,
  input wire logic        dev_reset_pulse,
  input wire logic        macro_enable,
  input wire logic        macro_default_pulse,
  input wire logic        settings_save,
  input wire logic        test_start,
  input wire logic        settings_restore,
  input wire logic [7:0]  event_enable_mask,
  input wire logic [7:0]  event_status_latch,
  input wire logic [7:0]  service_enable_mask,
  input wire logic [7:0]  summary_status_byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // command taken at this edge, by code
  wire logic tk = cmd_valid && cmd_ready;
  a_ese_query_echo: assert property (tk && cmd_code == `CSSC_CMD_ESE_QRY
    |=> out_valid && out_data == {8'h00, $past(event_enable_mask)})
    else $error("mask query value wrong");
  // bit 0 left out: a completion event may land on the read edge
  a_esr_read_clear: assert property (tk && cmd_code == `CSSC_CMD_ESR_QRY
    |=> out_data == {8'h00, $past(event_status_latch)}
    && (event_status_latch & 8'hfe) == ($past(event_in) & 8'hfe))
    else $error("event status not cleared by read");
  a_range_error: assert property (tk && cmd_code == `CSSC_CMD_ESE_SET
    && ($signed(cmd_param) > 16'sd255 || $signed(cmd_param) < 16'sd0)
    |=> $stable(event_enable_mask) && event_status_latch[4])
    else $error("out of range mask accepted");
  a_sre_bit6_low: assert property (service_enable_mask[6] == 1'b0)
    else $error("service mask bit 6 set");
  a_summary_bit: assert property (summary_status_byte[6] ==
    |(summary_status_byte & service_enable_mask & 8'hbf))
    else $error("summary status wrong");
  a_mav_slot: assert property (summary_status_byte[4] == out_valid)
    else $error("message available wrong");
  a_reset_keeps: assert property (tk && cmd_code == `CSSC_CMD_RST
    |=> dev_reset_pulse && macro_default_pulse && !macro_enable
    && $stable(event_enable_mask)
    && $stable(service_enable_mask))
    else $error("reset command effects wrong");
  a_test_order: assert property (tk && cmd_code == `CSSC_CMD_TST_QRY
    |=> settings_save ##1 test_start)
    else $error("self test start order wrong");
  a_restore_after: assert property (test_done |=> settings_restore)
    else $error("settings not restored");
  a_opcq_waits: assert property (tk && cmd_code == `CSSC_CMD_OPC_QRY
    && ops_pending ##1 ops_pending |-> !out_valid)
    else $error("completion answer too early");
  c_idn: cover property (tk && cmd_code == `CSSC_CMD_IDN_QRY);
  c_cls: cover property (tk && cmd_code == `CSSC_CMD_CLS);
  c_tst: cover property (settings_restore);
endmodule
bind cssc_handler cssc_monitor u_mon (.clk(clk), .reset(reset),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
  .cmd_param(cmd_param), .out_valid(out_valid), .out_data(out_data),
  .event_in(event_in), .ops_pending(ops_pending), .test_done(test_done),
  .dev_reset_pulse(dev_reset_pulse), .macro_enable(macro_enable),
  .macro_default_pulse(macro_default_pulse),
  .settings_save(settings_save), .test_start(test_start),
  .settings_restore(settings_restore),
  .event_enable_mask(event_enable_mask),
  .event_status_latch(event_status_latch),
  .service_enable_mask(service_enable_mask),
  .summary_status_byte(summary_status_byte));
`default_nettype wire

// ==== cssc_host_model.sv ====
// host model that pops the handler's output slot
// assumes one clock; stalls while hold is high
`timescale 1ns/1ps
`default_nettype none
module cssc_host_model (
  // clock and control
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hold,
  // output slot
  input  wire logic        out_valid,
  input  wire logic [15:0] out_data,
  input  wire logic [1:0]  out_kind,
  input  wire logic        out_more,
  output var  logic        out_read,
  // last word taken and count
  output var  logic [15:0] got_data,
  output var  logic [1:0]  got_kind,
  output var  logic        got_more,
  output var  logic [7:0]  got_cnt
);
  initial out_read = 1'b0;
  // one-cycle pops with a gap, slower than the design allows
  always @(posedge clk)
  begin
    if (out_read && out_valid)
    begin
      got_data <= out_data;
      got_kind <= out_kind;
      got_more <= out_more;
      got_cnt  <= got_cnt + 8'h01;
    end
    if (reset)
      got_cnt <= 8'h00;
    out_read <= !reset && out_valid && !hold && !out_read;
  end
endmodule
`default_nettype wire

// ==== test_cssc_handler.sv ====
// self-checking bench for the common status command handler
// assumes the host model pops responses; self-test answered here
`timescale 1ns/1ps
`default_nettype none
`include "cssc_defs.vh"
module test_cssc_handler;
  logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_param_half = 1'b0;
  logic cmd_after_term = 1'b0, ops_pending = 1'b0, test_done = 1'b0;
  logic hold = 1'b0, got_more, out_read, out_valid, out_more, cmd_ready;
  logic macro_enable, test_start;
  logic [3:0] cmd_code = 4'h0;
  logic [15:0] cmd_param = 16'h0, tst_val = 16'h0, got_data, out_data;
  logic [7:0] event_in = 8'h00, status_in = 8'h01, got_cnt, n_want = 8'h00;
  logic [1:0] got_kind, out_kind;
  integer n_fail = 0, tests_run = 0, j;
  always #5 clk = ~clk;
  cssc_handler #(.MAKER_ID(16'h1111), .MODEL_ID(16'h2222),
    .SERIAL_ID(16'h3333), .FIRMWARE_ID(16'h4444)) DUT (.clk(clk),
    .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_param(cmd_param), .cmd_after_term(cmd_after_term),
    .cmd_param_half(cmd_param_half), .out_valid(out_valid), .out_read(out_read),
    .out_data(out_data), .out_kind(out_kind), .out_more(out_more),
    .event_in(event_in), .status_in(status_in), .ops_pending(ops_pending),
    .dev_reset_pulse(), .macro_enable(macro_enable), .macro_default_pulse(),
    .test_start(test_start), .test_done(test_done), .test_result(tst_val),
    .settings_save(), .settings_restore(), .event_enable_mask(),
    .event_status_latch(), .service_enable_mask(), .summary_status_byte());
  cssc_host_model HOST (.clk(clk), .reset(reset), .hold(hold),
    .out_valid(out_valid), .out_data(out_data), .out_kind(out_kind),
    .out_more(out_more), .out_read(out_read), .got_data(got_data),
    .got_kind(got_kind), .got_more(got_more), .got_cnt(got_cnt));
  // self-test engine stand-in, answers three cycles after start
  always @(posedge clk)
    if (test_start === 1'b1)
    begin
      repeat (3) @(posedge clk);
      #1 test_done = 1'b1;
      @(posedge clk);
      #1 test_done = 1'b0;
    end
  task report_and_stop;
    begin
      if (n_fail == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task cmp(input [8*10:1] nm, input [18:0] exp, input [18:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
        n_fail = n_fail + 1;
      end
    end
  endtask
  // one command, held until taken; a gap edge first so valid never
  // changes twice in one step
  task send(input [3:0] c, input [15:0] p, input h, input t);
    integer i;
    begin
      tick;
      cmd_code = c;
      cmd_param = p;
      cmd_param_half = h;
      cmd_after_term = t;
      cmd_valid = 1'b1;
      for (i = 0; i < 200 && cmd_ready !== 1'b1; i = i + 1)
        tick;
      if (cmd_ready !== 1'b1)
        cmp("cmd_ready", 19'h1, {18'h0, cmd_ready});
      tick;
      cmd_valid = 1'b0;
    end
  endtask
  task resp(input [1:0] k, input m, input [15:0] d);
    integer i;
    begin
      n_want = n_want + 8'h01;
      for (i = 0; i < 200 && got_cnt !== n_want; i = i + 1)
        tick;
      if (got_cnt !== n_want)
        cmp("resp_wait", {11'h0, n_want}, {11'h0, got_cnt});
      cmp("response", {k, m, d}, {got_kind, got_more, got_data});
    end
  endtask
  task q(input [3:0] c, input [15:0] d);
    begin
      send(c, 16'h0, 1'b0, 1'b0);
      resp(`CSSC_KIND_NUM, 1'b0, d);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    q(`CSSC_CMD_ESE_QRY, 16'h0000);
    send(`CSSC_CMD_ESE_SET, 16'd32, 1'b0, 1'b0);
    q(`CSSC_CMD_ESE_QRY, 16'd32);
    send(`CSSC_CMD_ESE_SET, 16'd254, 1'b1, 1'b0);
    q(`CSSC_CMD_ESE_QRY, 16'd255);
    send(`CSSC_CMD_ESE_SET, 16'd255, 1'b1, 1'b0);
    send(`CSSC_CMD_ESE_SET, 16'hffff, 1'b0, 1'b0);
    q(`CSSC_CMD_ESE_QRY, 16'd255);
    q(`CSSC_CMD_ESR_QRY, 16'h0010);
    q(`CSSC_CMD_ESR_QRY, 16'h0000);
    send(`CSSC_CMD_SRE_SET, 16'h00ff, 1'b0, 1'b0);
    q(`CSSC_CMD_SRE_QRY, 16'h00bf);
    q(`CSSC_CMD_STB_QRY, 16'h0041);
    send(`CSSC_CMD_IDN_QRY, 16'h0, 1'b0, 1'b0);
    for (j = 0; j < 4; j = j + 1)
      resp(`CSSC_KIND_IDN, j < 3, 16'h1111 * (j + 1));
    ops_pending = 1'b1;
    send(`CSSC_CMD_OPC, 16'h0, 1'b0, 1'b0);
    repeat (3) tick;
    cmp("opc_early", 19'h0, {11'h0, DUT.event_status_latch});
    ops_pending = 1'b0;
    q(`CSSC_CMD_ESR_QRY, 16'h0001);
    ops_pending = 1'b1;
    send(`CSSC_CMD_OPC_QRY, 16'h0, 1'b0, 1'b0);
    repeat (4) tick;
    cmp("opcq_wait", {11'h0, n_want}, {11'h0, got_cnt});
    ops_pending = 1'b0;
    resp(`CSSC_KIND_CHAR, 1'b0, `CSSC_ASCII_ONE);
    q(`CSSC_CMD_ESR_QRY, 16'h0000);
    // clear-status also cancels a waiting completion query
    ops_pending = 1'b1;
    send(`CSSC_CMD_OPC_QRY, 16'h0, 1'b0, 1'b0);
    send(`CSSC_CMD_CLS, 16'h0, 1'b0, 1'b0);
    ops_pending = 1'b0;
    repeat (4) tick;
    cmp("opcq_drop", {11'h0, n_want}, {11'h0, got_cnt});
    // clear-status disarms a waiting completion command and drops old
    // events; an event landing on its own edge survives (set wins)
    ops_pending = 1'b1;
    event_in = 8'h08;
    send(`CSSC_CMD_OPC, 16'h0, 1'b0, 1'b0);
    event_in = 8'h04;
    send(`CSSC_CMD_CLS, 16'h0, 1'b0, 1'b0);
    event_in = 8'h00;
    ops_pending = 1'b0;
    repeat (3) tick;
    q(`CSSC_CMD_ESR_QRY, 16'h0004);
    hold = 1'b1;
    send(`CSSC_CMD_ESE_QRY, 16'h0, 1'b0, 1'b0);
    send(`CSSC_CMD_CLS, 16'h0, 1'b0, 1'b0);
    hold = 1'b0;
    resp(`CSSC_KIND_NUM, 1'b0, 16'd255);
    hold = 1'b1;
    send(`CSSC_CMD_ESE_QRY, 16'h0, 1'b0, 1'b0);
    send(`CSSC_CMD_CLS, 16'h0, 1'b0, 1'b1);
    tick;
    cmp("flushed", 19'h0, {18'h0, out_valid});
    hold = 1'b0;
    send(`CSSC_CMD_RST, 16'h0, 1'b0, 1'b0);
    cmp("macro_en", 19'h0, {18'h0, macro_enable});
    q(`CSSC_CMD_ESE_QRY, 16'd255);
    q(`CSSC_CMD_SRE_QRY, 16'h00bf);
    tst_val = 16'h0000;
    q(`CSSC_CMD_TST_QRY, 16'h0000);
    tst_val = 16'h0005;
    q(`CSSC_CMD_TST_QRY, 16'h0005);
    tst_val = 16'h8000;
    q(`CSSC_CMD_TST_QRY, 16'h8001);
    report_and_stop;
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    #200000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule
`default_nettype wire
